// >>> rtl/pprl_regs.vh
// Constants for the port pin readback block: bank addresses, widths, resets.
// Assumes inclusion by bare name from the rtl/ design files.
`ifndef PPRL_REGS_VH
`define PPRL_REGS_VH

// Register address within a bank
`define PPRL_PORT_ADDR       1'b0
// Bank select value that reaches the direction register
`define PPRL_BANK_DIR        1'b1
// Bank select value that reaches the port data register
`define PPRL_BANK_DATA       1'b0
// Port width
`define PPRL_WIDTH           8
// Reset value of the direction register: all inputs
`define PPRL_DIR_RESET       8'hff
// Reset value of the output latch
`define PPRL_LATCH_RESET     8'h00
// Reset value of the analog configuration: all digital
`define PPRL_ANALOG_RESET    8'h00
// Index of the open-drain pin
`define PPRL_OD_PIN          4
// Access command codes
`define PPRL_OP_NONE         2'h0
`define PPRL_OP_WRITE        2'h1
`define PPRL_OP_BSET         2'h2
`define PPRL_OP_BCLR         2'h3

`endif

// >>> rtl/pprl_pin_cell.v
// One port pin: input sampling, analog gating and output driver control.
// Assumes pin input synchronous to clk; pad resolves wire from out/oe.
`timescale 1ns/1ps
`include "pprl_regs.vh"

module pprl_pin_cell #(
  parameter OPEN_DRAIN = 0
) (
  input  wire clk,
  input  wire reset_n,
  input  wire pin_in,
  input  wire latch_bit,
  input  wire dir_bit,
  input  wire analog_bit,
  output reg  sample_bit,
  output reg  pin_out,
  output reg  pin_oe
);

  // Sample pin level; analog pins read zero, buffer disabled
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_bit <= 1'b0;
    end else begin
      sample_bit <= pin_in & ~analog_bit;
    end
  end

  // Driver: direction zero drives latch; open-drain only pulls low
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else if (OPEN_DRAIN != 0) begin
      pin_out <= 1'b0;
      pin_oe  <= ~dir_bit & ~latch_bit;
    end else begin
      pin_out <= latch_bit;
      pin_oe  <= ~dir_bit;
    end
  end

endmodule // pprl_pin_cell

// >>> rtl/pprl_port.v
// General purpose port: output latch, direction register, pin readback.
// Bit operations on the latch start from the sampled pins, as a read does.
// Assumes one access command per cycle from the core, synchronous pins.
// Assumes the pad resolves each pin from pin_out and pin_oe.
// Assumes the open-drain pin has a pull-up on the board.
// Assumes bit_index stays below WIDTH.
`timescale 1ns/1ps
`include "pprl_regs.vh"

// Contract
// - Port read returns sampled pin levels
// - Output pin held low reads zero
// - Open-drain pin drives low or floats
// - Analog pins read zero, buffer disabled
// - Analog pin may still drive as output
// - Bit operations write sampled pins into latch
// - Bit set rewrites other bits from pins
// - Direction reached only with bank select set
// - Direction one floats, zero drives latch
// - Write at cycle end, read sampled earlier
// - Latch holds until software writes again
module pprl_port #(
  parameter WIDTH = `PPRL_WIDTH,
  parameter OD_PIN = `PPRL_OD_PIN
) (
  input  wire                     clk,
  input  wire                     reset_n,
  input  wire [1:0]               op,
  input  wire                     bank_select_bit,
  input  wire [WIDTH-1:0]         wr_data,
  input  wire [2:0]               bit_index,
  input  wire                     rd_en,
  input  wire [WIDTH-1:0]         analog_pin_config,
  input  wire [WIDTH-1:0]         pin_in,
  output reg  [WIDTH-1:0]         rd_data,
  output reg                      rd_valid,
  output wire [WIDTH-1:0]         pin_out,
  output wire [WIDTH-1:0]         pin_oe
);

  // Reset images sized to the port
  localparam [WIDTH-1:0] LATCH_INIT = `PPRL_LATCH_RESET;
  localparam [WIDTH-1:0] DIR_INIT   = `PPRL_DIR_RESET;
  localparam [WIDTH-1:0] ZERO       = {WIDTH{1'b0}};

  // Output latch and direction register
  reg  [WIDTH-1:0] latch_reg;
  reg  [WIDTH-1:0] latch_next;
  reg  [WIDTH-1:0] direction_reg;
  reg  [WIDTH-1:0] direction_next;
  // Next read result and strobe
  reg  [WIDTH-1:0] rd_data_next;
  reg              rd_valid_next;
  // Base of a bit operation on the latch
  reg  [WIDTH-1:0] rmw_base;

  // Pin levels sampled by the pin cells
  wire [WIDTH-1:0] sample;

  // Access decode
  wire             hit_data;
  wire             hit_dir;
  wire             latch_touch;
  wire             direction_touch;
  wire             rd_from_dir;
  wire             rd_from_pins;
  wire [WIDTH-1:0] target_mask;

  // One-hot mask of the targeted bit
  function [WIDTH-1:0] pprl_bit_mask;
    input [2:0] idx;
    begin
      pprl_bit_mask = {{(WIDTH-1){1'b0}}, 1'b1} << idx;
    end
  endfunction

  // True when the bank select reaches the wanted register
  function pprl_bank_hit;
    input sel;
    input want;
    begin
      pprl_bank_hit = (sel == want);
    end
  endfunction

  // True when the command changes a register
  function pprl_cmd_active;
    input [1:0] code;
    begin
      pprl_cmd_active = (code != `PPRL_OP_NONE);
    end
  endfunction

  // One command applied to a register image; base feeds bit operations
  function [WIDTH-1:0] pprl_apply_op;
    input [1:0]       code;
    input [WIDTH-1:0] held;
    input [WIDTH-1:0] base;
    input [WIDTH-1:0] data;
    input [WIDTH-1:0] mask;
    begin
      case (code)
        `PPRL_OP_WRITE: begin
          pprl_apply_op = data;
        end
        `PPRL_OP_BSET: begin
          pprl_apply_op = base | mask;
        end
        `PPRL_OP_BCLR: begin
          pprl_apply_op = base & ~mask;
        end
        default: begin
          pprl_apply_op = held;
        end
      endcase
    end
  endfunction

  // Bank and command decode shared by both registers and the readback
  assign hit_dir         = pprl_bank_hit(bank_select_bit, `PPRL_BANK_DIR);
  assign hit_data        = pprl_bank_hit(bank_select_bit, `PPRL_BANK_DATA);
  assign latch_touch     = hit_data && pprl_cmd_active(op);
  assign direction_touch = hit_dir && pprl_cmd_active(op);
  assign rd_from_dir     = rd_en && hit_dir;
  assign rd_from_pins    = rd_en && hit_data;
  // Mask of the bit that a bit operation targets
  assign target_mask     = pprl_bit_mask(bit_index);

  // Per-pin sampling and drivers
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_pin
      // Open-drain stage only on the chosen pin
      pprl_pin_cell #(
        .OPEN_DRAIN (gi == OD_PIN)
      ) u_cell (
        .clk        (clk),
        .reset_n    (reset_n),
        .pin_in     (pin_in[gi]),
        .latch_bit  (latch_reg[gi]),
        .dir_bit    (direction_reg[gi]),
        .analog_bit (analog_pin_config[gi]),
        .sample_bit (sample[gi]),
        .pin_out    (pin_out[gi]),
        .pin_oe     (pin_oe[gi])
      );
    end
  endgenerate

  // Bit operations on the latch start from the sampled pins
  always @* begin
    rmw_base = sample;
  end

  // Latch next state: data-bank commands only, else it holds
  always @* begin
    if (latch_touch) begin
      latch_next = pprl_apply_op(op, latch_reg, rmw_base,
                                 wr_data, target_mask);
    end else begin
      latch_next = latch_reg;
    end
  end

  // Direction next state: bit operations use the register itself
  always @* begin
    if (direction_touch) begin
      direction_next = pprl_apply_op(op, direction_reg, direction_reg,
                                     wr_data, target_mask);
    end else begin
      direction_next = direction_reg;
    end
  end

  // Latch written at the end of the access cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_reg <= LATCH_INIT;
    end else begin
      latch_reg <= latch_next;
    end
  end

  // Direction register, all inputs after reset
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      direction_reg <= DIR_INIT;
    end else begin
      direction_reg <= direction_next;
    end
  end

  // Read source: direction bank returns the register, data bank the pins
  always @* begin
    rd_valid_next = rd_en;
    if (rd_from_dir) begin
      rd_data_next = direction_reg;
    end else if (rd_from_pins) begin
      rd_data_next = sample;
    end else begin
      rd_data_next = rd_data;
    end
  end

  // Read data, held between reads
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= ZERO;
    end else begin
      rd_data <= rd_data_next;
    end
  end

  // One-cycle read strobe
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_valid_next;
    end
  end

endmodule // pprl_port

// >>> tb/pprl_props.sv
// Checker of read timing and pin drive of pprl_port.
// Assumes binding onto pprl_port, ports only.
`timescale 1ns/1ps
module pprl_props (
  input wire       clk,
  input wire       reset_n,
  input wire       rd_en,
  input wire       rd_valid,
  input wire       bank_select_bit,
  input wire [1:0] op,
  input wire [2:0] bit_index,
  input wire [7:0] wr_data,
  input wire [7:0] analog_pin_config,
  input wire [7:0] pin_in,
  input wire [7:0] rd_data,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  rd_pulse_a: assert property (1 |=> rd_valid == $past(rd_en)) else $error("valid");
  rd_pins_a: assert property (rd_en && !bank_select_bit |=>
    rd_data == ($past(pin_in, 2) & ~$past(analog_pin_config, 2))) else $error("read");
  od_low_a: assert property (!(pin_oe[4] && pin_out[4])) else $error("od");
  od_float_a: assert property (op == 2'h1 && !bank_select_bit && wr_data[4] ##1 op == 2'h0 |=>
    !pin_oe[4]) else $error("od float");
  dir_float_a: assert property (op == 2'h1 && bank_select_bit ##1 op == 2'h0 |=>
    (pin_oe & $past(wr_data, 2)) == 8'h00) else $error("dir");
  latch_drv_a: assert property (op == 2'h1 && !bank_select_bit ##1 op == 2'h0 |=>
    ((pin_out ^ $past(wr_data, 2)) & pin_oe) == 8'h00) else $error("write");
  pin_hold_a: assert property ((op == 2'h0) [*2] |=> $stable(pin_out) && $stable(pin_oe))
    else $error("hold");
  bit_set_a: assert property (op == 2'h2 && !bank_select_bit ##1 op == 2'h0 |=>
    ((pin_out ^ ($past(pin_in, 3) & ~$past(analog_pin_config, 3)
    | 8'h01 << $past(bit_index, 2))) & pin_oe) == 8'h00) else $error("set");
  rd_keep_a: assert property (!rd_en |=> $stable(rd_data)) else $error("keep");
endmodule // pprl_props
bind pprl_port pprl_props i_props (.*);

// >>> tb/pprl_pin_load.sv
// Board loads on the port pins.
// Assumes the port samples these levels on its clock.
`timescale 1ns/1ps
module pprl_pin_load (
  input  wire [7:0] pin_out,
  input  wire [7:0] pin_oe,
  input  wire [7:0] ext,
  input  wire [7:0] gnd,
  output wire [7:0] pin_in
);
  // Driven bits follow the port, others the board; open-drain pin pulled up, shorts win
  assign pin_in = ((pin_oe & pin_out) | (~pin_oe & (ext | 8'h10))) & ~gnd;
endmodule // pprl_pin_load

// >>> tb/port_pin_readback_logic_tb.sv
// Bench for pprl_port with a board load model.
// Assumes pins fed back only by pprl_pin_load.
`timescale 1ns/1ps
module port_pin_readback_logic_tb;
  reg        clk = 0, reset_n = 0, bank_select_bit = 0, rd_en = 0;
  reg  [1:0] op = 2'h0;
  reg  [2:0] bit_index = 3'h0;
  reg  [7:0] wr_data = 8'h00, analog_pin_config = 8'h02, ext = 8'h00, gnd = 8'h04;
  wire [7:0] pin_in, rd_data, pin_out, pin_oe;
  wire       rd_valid;
  integer    fails = 0, compares = 0, seed = 17613, k;
  reg  [31:0] rnd;
  reg  [7:0] m_lat = 8'h00, m_dir = 8'hff, m_smp = 8'h00, m_rd = 8'h00;
  reg  [7:0] m_out = 8'h00, m_oe = 8'h00;
  reg        m_vld = 1'b0;
  // Clock, design and board
  always #20 clk = ~clk;
  pprl_port i_dut (.*);
  pprl_pin_load i_load (.*);
  // Settled read of given pin levels
  function [7:0] exp_rd(input [7:0] lvl);
    exp_rd = lvl & ~gnd & ~analog_pin_config;
  endfunction
  // Register image after one command; base feeds bit operations
  function [7:0] exp_next(input [1:0] o, input [7:0] h, input [7:0] base, input [7:0] d,
                          input [2:0] i);
    case (o)
      2'h1: exp_next = d;
      2'h2: exp_next = base | (8'h01 << i);
      2'h3: exp_next = base & ~(8'h01 << i);
      default: exp_next = h;
    endcase
  endfunction
  // Reference port: pins sampled, reads one edge late, pins one edge after the latch
  always @(posedge clk) begin
    if (reset_n) begin
      m_smp <= pin_in & ~analog_pin_config;
      m_vld <= rd_en;
      if (rd_en)
        m_rd <= bank_select_bit ? m_dir : m_smp;
      if (bank_select_bit)
        m_dir <= exp_next(op, m_dir, m_dir, wr_data, bit_index);
      else
        m_lat <= exp_next(op, m_lat, m_smp, wr_data, bit_index);
      m_out <= m_lat & 8'hef;
      m_oe  <= ~m_dir & ~(m_lat & 8'h10);
    end
  end
  task cmp(input [7:0] s, input [7:0] e, input string nm);
    compares = compares + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task go(input [1:0] o, input b, input [7:0] d, input [2:0] i, input integer n);
    op = o;
    bank_select_bit = b;
    wr_data = d;
    bit_index = i;
    @(negedge clk);
    if (n > 0)
      op = 2'h0;
    repeat (n) @(negedge clk);
  endtask
  task end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Directed corners, then random traffic
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1;
    go(2'h1, 1, 8'h00, 3'h0, 0);
    go(2'h1, 0, 8'hff, 3'h0, 4);
    rd_en = 1;
    @(negedge clk);
    cmp(rd_valid, 8'h01, "rd_valid");
    rd_en = 0;
    @(negedge clk);
    cmp(rd_data, exp_rd(8'hff), "rd_data");
    cmp(rd_valid, 8'h00, "rd_valid");
    go(2'h2, 0, 8'h00, 3'h0, 4);
    cmp(pin_out, exp_rd(8'hef) | 8'h01, "pin_out");
    go(2'h1, 0, 8'h00, 3'h0, 4);
    go(2'h2, 0, 8'h00, 3'h7, 0);
    go(2'h2, 0, 8'h00, 3'h6, 4);
    cmp(pin_out, 8'h40, "pin_out");
    for (k = 0; k < 400; k = k + 1) begin
      rnd = $random(seed);
      {analog_pin_config, op, bank_select_bit, bit_index, rd_en, wr_data, ext} = rnd[30:0];
      @(negedge clk);
      cmp(rd_data, m_rd, "rd_data");
      cmp(rd_valid, {7'h00, m_vld}, "rd_valid");
      cmp(pin_out, m_out, "pin_out");
      cmp(pin_oe, m_oe, "pin_oe");
    end
    end_of_test;
  end
  // Watchdog
  initial begin
    #100000;
    fails = fails + 1;
    end_of_test;
  end
endmodule // port_pin_readback_logic_tb
